// File: hdl/lfo_pkg.sv
package lfo_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] EXT_OFS = 8'h14;
  localparam logic [7:0] INT_OFS = 8'h18;
  localparam logic [7:0] ULP_OFS = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
  localparam logic [7:0] READY_OFS = 8'h2C;
  localparam logic [15:0] EXT_RESET = 16'h0080;
  localparam logic [31:0] INT_RESET = 32'h00000080;
  localparam logic [7:0] ULP_RESET = 8'h00;
  localparam int EXT_LOCK_BIT = 12;
  localparam int STARTUP_LSB = 8;
  localparam int REQUEST_GATED_RUN_BIT = 7;
  localparam int STDBY_BIT = 6;
  localparam int AAMP_BIT = 5;
  localparam int LOW_FREQ_OUTPUT_ENABLE_BIT = 3;
  localparam int XTAL_BIT = 2;
  localparam int ENABLE_BIT = 1;
  localparam int INT_TRIM_LSB = 16;
  localparam int INT_LOCK_BIT = 12;
  localparam int ULP_LOCK_BIT = 7;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] SYNC_CYCLES = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic write_lock_bit;
    logic [2:0] startup;
    logic request_gated_run;
    logic keep_running_in_sleep;
    logic auto_amplitude_enable;
    logic low_freq_output_enable;
    logic crystal_pad_select;
    logic enable;
  } lfo_ext_s;

  typedef enum logic [1:0] {ST_OFF, ST_WARM, ST_SYNC, ST_READY} lfo_state_e;

  function automatic logic [17:0] startup_len(input logic [2:0] code);
    case (code)
      3'h0: startup_len = 18'h00001;
      3'h1: startup_len = 18'h00020;
      3'h2: startup_len = 18'h00800;
      3'h3: startup_len = 18'h01000;
      3'h4: startup_len = 18'h04000;
      3'h5: startup_len = 18'h08000;
      3'h6: startup_len = 18'h10000;
      default: startup_len = 18'h20000;
    endcase
  endfunction

  function automatic logic [31:0] ext_word(input lfo_ext_s s);
    ext_word = 32'h0;
    ext_word[EXT_LOCK_BIT] = s.write_lock_bit;
    ext_word[STARTUP_LSB+:3] = s.startup;
    ext_word[REQUEST_GATED_RUN_BIT] = s.request_gated_run;
    ext_word[STDBY_BIT] = s.keep_running_in_sleep;
    ext_word[AAMP_BIT] = s.auto_amplitude_enable;
    ext_word[LOW_FREQ_OUTPUT_ENABLE_BIT] = s.low_freq_output_enable;
    ext_word[XTAL_BIT] = s.crystal_pad_select;
    ext_word[ENABLE_BIT] = s.enable;
  endfunction

  function automatic lfo_ext_s ext_from(input logic [31:0] w);
    ext_from.write_lock_bit = w[EXT_LOCK_BIT];
    ext_from.startup = w[STARTUP_LSB+:3];
    ext_from.request_gated_run = w[REQUEST_GATED_RUN_BIT];
    ext_from.keep_running_in_sleep = w[STDBY_BIT];
    ext_from.auto_amplitude_enable = w[AAMP_BIT];
    ext_from.low_freq_output_enable = w[LOW_FREQ_OUTPUT_ENABLE_BIT];
    ext_from.crystal_pad_select = w[XTAL_BIT];
    ext_from.enable = w[ENABLE_BIT];
  endfunction
endpackage

// File: hdl/lfo_ctrl.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Reserved bits read zero; software writes zero.
// - Crystal register lock ignores later writes.
// - Warm-up field sets count on low-power clock.
// - Codes map to 1..131072 low-power cycles.
// - Three crystal cycles sync before ready.
// - On-demand runs only while a request present.
// - Without on-demand, enabled oscillator runs always outside standby.
// - Standby without keep-running stops the oscillator.
// - Standby with keep-running follows on-demand setting.
// - Amplitude-control bit enables automatic regulation.
// - Output-enable bit gates the 32kHz output.
// - Pad select: external clock or crystal.
// - Enable bit switches crystal oscillator on/off.
// - Internal trim written by software only.
// - Internal register lock rejects later writes.
// - Low-power register offers its own lock.
module lfo_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [lfo_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready_q,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready_q,
  output logic [1:0] bresp_q,
  output logic bvalid_q,
  input wire logic bready,
  input wire logic [lfo_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready_q,
  output logic [31:0] rdata_q,
  output logic [1:0] rresp_q,
  output logic rvalid_q,
  input wire logic rready,
  input wire logic ulp_clk_in,
  input wire logic low_freq_in_pad,
  input wire logic clk_request,
  input wire logic standby_sleep,
  output logic osc_run_q,
  output logic auto_amp_q,
  output logic out_32k_en_q,
  output logic crystal_pad_select_q,
  output logic low_freq_out_pad_release_q,
  output logic ext_crystal_ready_flag_q,
  output logic [6:0] int_osc_trim_q,
  output logic [4:0] ulp_trim_q,
  output logic irq_q
);
  lfo_pkg::lfo_ext_s ext_q;
  lfo_pkg::lfo_state_e state_q;
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic ulp_edge, xtal_edge;
  logic aw_held_q, w_held_q;
  logic [lfo_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, wr_merged, clr_bits;
  logic [3:0] wstrb_q;
  logic do_write, aw_fire, w_fire, ar_fire;
  logic wr_ext, wr_int, wr_ulp, wr_stat, wr_mask, wr_hit;
  logic int_lock_q, ulp_lock_q;
  logic [lfo_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic [17:0] cnt_q;
  logic [1:0] sync_cnt_q;
  logic run_req, demand_ok;
  logic [31:0] rd_word, cur_word;
  logic rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8+:8] = nw[i*8+:8];
      end
    end
  endfunction

  // Pin inputs pass two flip-flops; the third stage only finds edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else if (clk_en) begin
      pin_s1_q <= {ulp_clk_in, low_freq_in_pad};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign ulp_edge = pin_s2_q[1] & ~pin_s3_q[1];
  assign xtal_edge = pin_s2_q[0] & ~pin_s3_q[0];

  assign aw_fire = awvalid & awready_q;
  assign w_fire = wvalid & wready_q;
  assign ar_fire = arvalid & arready_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;

  always_comb begin
    wr_ext = awaddr_q[7:2] == lfo_pkg::EXT_OFS[7:2];
    wr_int = awaddr_q[7:2] == lfo_pkg::INT_OFS[7:2];
    wr_ulp = awaddr_q[7:2] == lfo_pkg::ULP_OFS[7:2];
    wr_stat = awaddr_q[7:2] == lfo_pkg::IRQ_STAT_OFS[7:2];
    wr_mask = awaddr_q[7:2] == lfo_pkg::IRQ_MASK_OFS[7:2];
    wr_hit = wr_ext | wr_int | wr_ulp | wr_stat | wr_mask |
             (awaddr_q[7:2] == lfo_pkg::READY_OFS[7:2]);
    cur_word = 32'h0;
    if (wr_ext) begin
      cur_word = lfo_pkg::ext_word(ext_q);
    end else if (wr_int) begin
      cur_word[lfo_pkg::INT_TRIM_LSB+:7] = int_osc_trim_q;
      cur_word[lfo_pkg::INT_LOCK_BIT] = int_lock_q;
    end else if (wr_ulp) begin
      cur_word[4:0] = ulp_trim_q;
      cur_word[lfo_pkg::ULP_LOCK_BIT] = ulp_lock_q;
    end
    wr_merged = merge(cur_word, wdata_q, wstrb_q);
    clr_bits = merge(32'h0, wdata_q, wstrb_q);
  end

  // Write channels are taken in either order; response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= lfo_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? lfo_pkg::RESP_OKAY : lfo_pkg::RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Configuration registers; a set lock blocks later writes to its own register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= lfo_pkg::ext_from({16'h0, lfo_pkg::EXT_RESET});
      int_osc_trim_q <= lfo_pkg::INT_RESET[lfo_pkg::INT_TRIM_LSB+:7];
      int_lock_q <= lfo_pkg::INT_RESET[lfo_pkg::INT_LOCK_BIT];
      ulp_trim_q <= lfo_pkg::ULP_RESET[4:0];
      ulp_lock_q <= lfo_pkg::ULP_RESET[lfo_pkg::ULP_LOCK_BIT];
      irq_mask_q <= '0;
    end else if (clk_en && do_write) begin
      if (wr_ext && !ext_q.write_lock_bit) begin
        ext_q <= lfo_pkg::ext_from(wr_merged);
      end
      if (wr_int && !int_lock_q) begin
        int_osc_trim_q <= wr_merged[lfo_pkg::INT_TRIM_LSB+:7];
        int_lock_q <= wr_merged[lfo_pkg::INT_LOCK_BIT];
      end
      if (wr_ulp && !ulp_lock_q) begin
        ulp_trim_q <= wr_merged[4:0];
        ulp_lock_q <= wr_merged[lfo_pkg::ULP_LOCK_BIT];
      end
      if (wr_mask) begin
        irq_mask_q <= wr_merged[lfo_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (do_write && wr_stat) begin
        irq_stat_q <= (irq_stat_q & ~clr_bits[lfo_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (araddr[7:2])
      lfo_pkg::EXT_OFS[7:2]: rd_word = lfo_pkg::ext_word(ext_q);
      lfo_pkg::INT_OFS[7:2]: begin
        rd_word[lfo_pkg::INT_TRIM_LSB+:7] = int_osc_trim_q;
        rd_word[lfo_pkg::INT_LOCK_BIT] = int_lock_q;
      end
      lfo_pkg::ULP_OFS[7:2]: begin
        rd_word[4:0] = ulp_trim_q;
        rd_word[lfo_pkg::ULP_LOCK_BIT] = ulp_lock_q;
      end
      lfo_pkg::IRQ_STAT_OFS[7:2]: rd_word[lfo_pkg::IRQ_W-1:0] = irq_stat_q;
      lfo_pkg::IRQ_MASK_OFS[7:2]: rd_word[lfo_pkg::IRQ_W-1:0] = irq_mask_q;
      lfo_pkg::READY_OFS[7:2]: rd_word[0] = ext_crystal_ready_flag_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= lfo_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_fire) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? lfo_pkg::RESP_OKAY : lfo_pkg::RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Run decision from enable, on-demand, standby and requests.
  always_comb begin
    demand_ok = !ext_q.request_gated_run || clk_request;
    if (standby_sleep) begin
      run_req = ext_q.enable && ext_q.keep_running_in_sleep &&
                demand_ok;
    end else begin
      run_req = ext_q.enable && demand_ok;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_run_q <= 1'b0;
      auto_amp_q <= 1'b0;
      out_32k_en_q <= 1'b0;
      crystal_pad_select_q <= 1'b0;
      low_freq_out_pad_release_q <= 1'b1;
    end else if (clk_en) begin
      osc_run_q <= run_req;
      auto_amp_q <= run_req && ext_q.auto_amplitude_enable;
      out_32k_en_q <= run_req && ext_q.low_freq_output_enable;
      crystal_pad_select_q <= ext_q.crystal_pad_select;
      low_freq_out_pad_release_q <= !ext_q.crystal_pad_select;
    end
  end

  // Warm-up on low-power ticks, then sync on crystal edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= lfo_pkg::ST_OFF;
      cnt_q <= 18'h0;
      sync_cnt_q <= 2'h0;
      ext_crystal_ready_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (!osc_run_q) begin
        state_q <= lfo_pkg::ST_OFF;
        ext_crystal_ready_flag_q <= 1'b0;
      end else begin
        case (state_q)
          lfo_pkg::ST_OFF: begin
            state_q <= lfo_pkg::ST_WARM;
            cnt_q <= lfo_pkg::startup_len(ext_q.startup);
          end
          lfo_pkg::ST_WARM: begin
            if (ulp_edge) begin
              cnt_q <= cnt_q - 18'h1;
              if (cnt_q == 18'h1) begin
                state_q <= lfo_pkg::ST_SYNC;
                sync_cnt_q <= lfo_pkg::SYNC_CYCLES;
              end
            end
          end
          lfo_pkg::ST_SYNC: begin
            if (xtal_edge) begin
              sync_cnt_q <= sync_cnt_q - 2'h1;
              if (sync_cnt_q == 2'h1) begin
                state_q <= lfo_pkg::ST_READY;
                ext_crystal_ready_flag_q <= 1'b1;
              end
            end
          end
          lfo_pkg::ST_READY: ext_crystal_ready_flag_q <= 1'b1;
          default: state_q <= lfo_pkg::ST_OFF;
        endcase
      end
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[lfo_pkg::IRQ_READY_BIT] = clk_en && osc_run_q && xtal_edge &&
        state_q == lfo_pkg::ST_SYNC && sync_cnt_q == 2'h1;
    irq_ev[lfo_pkg::IRQ_LOST_BIT] = clk_en && !osc_run_q &&
        state_q == lfo_pkg::ST_READY;
  end

  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && ar_fire && araddr[7:2] == lfo_pkg::EXT_OFS[7:2]) |=>
    (rdata_q[31:13] == 19'h0 && rdata_q[11] == 1'b0 &&
     rdata_q[4] == 1'b0 && rdata_q[0] == 1'b0))
    else $error("Reserved crystal bits read nonzero.");
  AST_EXT_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_q.write_lock_bit |=> (ext_q == $past(ext_q)))
    else $error("Locked crystal register changed.");
  AST_WARM_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && osc_run_q && state_q == lfo_pkg::ST_OFF) |=>
    (cnt_q == lfo_pkg::startup_len($past(ext_q.startup))))
    else $error("Warm-up length wrong.");
  AST_WARM_ULP: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && osc_run_q && state_q == lfo_pkg::ST_WARM && !ulp_edge) |=>
    (cnt_q == $past(cnt_q)))
    else $error("Warm-up counted without a low-power tick.");
  AST_SYNC_THREE: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && osc_run_q && state_q == lfo_pkg::ST_WARM && ulp_edge &&
     cnt_q == 18'h1) |=> (state_q == lfo_pkg::ST_SYNC &&
     sync_cnt_q == lfo_pkg::SYNC_CYCLES && !ext_crystal_ready_flag_q))
    else $error("Sync stage not entered with three cycles.");
  AST_READY_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !osc_run_q) |=> (!ext_crystal_ready_flag_q &&
     state_q == lfo_pkg::ST_OFF))
    else $error("Ready flag held while oscillator off.");
  AST_RUN_DEMAND: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && ext_q.request_gated_run && !clk_request) |=> !osc_run_q)
    else $error("On-demand oscillator ran without request.");
  AST_RUN_CONT: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && ext_q.enable && !ext_q.request_gated_run && !standby_sleep)
    |=> osc_run_q)
    else $error("Enabled oscillator not running.");
  AST_STBY_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && standby_sleep && !ext_q.keep_running_in_sleep) |=> !osc_run_q)
    else $error("Oscillator ran in standby.");
  AST_STBY_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && standby_sleep && ext_q.keep_running_in_sleep &&
     ext_q.enable && demand_ok) |=> osc_run_q)
    else $error("Oscillator stopped in standby.");
  AST_EN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !ext_q.enable) |=> (!osc_run_q && !out_32k_en_q))
    else $error("Disabled oscillator running.");
  AST_GATED_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_32k_en_q || auto_amp_q) |-> osc_run_q)
    else $error("Output or regulation on while stopped.");
  AST_PADS: assert property (@(posedge aclk) disable iff (!aresetn)
    crystal_pad_select_q != low_freq_out_pad_release_q)
    else $error("Pad selection inconsistent.");
  AST_INT_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    int_lock_q |=> (int_lock_q && int_osc_trim_q == $past(int_osc_trim_q)))
    else $error("Locked internal register changed.");
  AST_ULP_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    ulp_lock_q |=> (ulp_lock_q && ulp_trim_q == $past(ulp_trim_q)))
    else $error("Locked low-power register changed.");
endmodule
`default_nettype wire

// File: test/low_freq_osc_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module low_freq_osc_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [lfo_pkg::ADDR_W-1:0] awaddr = 8'h00;
  logic [lfo_pkg::ADDR_W-1:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic ulp_clk_in = 1'b0, low_freq_in_pad = 1'b0;
  logic clk_request = 1'b0, standby_sleep = 1'b0;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic osc_run_q, auto_amp_q, out_32k_en_q, crystal_pad_select_q;
  logic low_freq_out_pad_release_q, ext_crystal_ready_flag_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [6:0] int_osc_trim_q;
  logic [4:0] ulp_trim_q;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  // Each entry is on-demand, keep-running, standby, request, expected run.
  localparam logic [4:0] MODES [8] = '{5'h10, 5'h13, 5'h01, 5'h06,
                                       5'h16, 5'h09, 5'h1C, 5'h1F};

  lfo_ctrl uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready_q(awready_q),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready_q(wready_q),
    .bresp_q(bresp_q), .bvalid_q(bvalid_q), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready_q(arready_q),
    .rdata_q(rdata_q), .rresp_q(rresp_q), .rvalid_q(rvalid_q),
    .rready(rready), .ulp_clk_in(ulp_clk_in),
    .low_freq_in_pad(low_freq_in_pad), .clk_request(clk_request),
    .standby_sleep(standby_sleep), .osc_run_q(osc_run_q),
    .auto_amp_q(auto_amp_q), .out_32k_en_q(out_32k_en_q),
    .crystal_pad_select_q(crystal_pad_select_q),
    .low_freq_out_pad_release_q(low_freq_out_pad_release_q),
    .ext_crystal_ready_flag_q(ext_crystal_ready_flag_q),
    .int_osc_trim_q(int_osc_trim_q), .ulp_trim_q(ulp_trim_q),
    .irq_q(irq_q));

  always #2 aclk = ~aclk;

  always begin
    repeat (4) @(posedge aclk);
    ulp_clk_in <= ~ulp_clk_in;
  end

  always begin
    repeat (3) @(posedge aclk);
    low_freq_in_pad <= ~low_freq_in_pad;
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready_q) awvalid <= 1'b0;
      if (wvalid && wready_q) wvalid <= 1'b0;
    end while (bvalid_q !== 1'b1 && k < 100);
    bready <= 1'b0;
    chk({29'h0, bvalid_q, bresp_q}, {29'h0, 1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready_q) arvalid <= 1'b0;
    end while (rvalid_q !== 1'b1 && k < 100);
    rready <= 1'b0;
    chk({29'h0, rvalid_q, rresp_q}, {29'h0, 1'b1, er});
    chk(rdata_q, ed);
  endtask

  task automatic wait_ready(output int cyc);
    int k;
    k = 0;
    while (ext_crystal_ready_flag_q !== 1'b1 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    cyc = k;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(lfo_pkg::EXT_OFS, {16'h0, lfo_pkg::EXT_RESET}, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::INT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::ULP_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, lfo_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFFFFFFFF, lfo_pkg::RESP_SLVERR);
    wr(lfo_pkg::EXT_OFS, 32'hFFFFEFFD, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::EXT_OFS, 32'h000007EC, lfo_pkg::RESP_OKAY);
    chk_bit(crystal_pad_select_q, 1'b1);
    chk_bit(low_freq_out_pad_release_q, 1'b0);
    chk_bit(osc_run_q, 1'b0);
    chk_bit(auto_amp_q, 1'b0);
    wr(lfo_pkg::EXT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    idle(2);
    chk_bit(low_freq_out_pad_release_q, 1'b1);
    wr(lfo_pkg::IRQ_MASK_OFS, 32'h1, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::EXT_OFS, 32'h0000002A, lfo_pkg::RESP_OKAY);
    wait_ready(n);
    chk_bit(n >= 12 && n <= 50, 1'b1);
    chk_bit(osc_run_q, 1'b1);
    chk_bit(auto_amp_q, 1'b1);
    chk_bit(out_32k_en_q, 1'b1);
    rd(lfo_pkg::READY_OFS, 32'h1, lfo_pkg::RESP_OKAY);
    idle(2);
    chk_bit(irq_q, 1'b1);
    wr(lfo_pkg::IRQ_STAT_OFS, 32'h1, lfo_pkg::RESP_OKAY);
    idle(2);
    chk_bit(irq_q, 1'b0);
    wr(lfo_pkg::EXT_OFS, 32'h00000028, lfo_pkg::RESP_OKAY);
    idle(3);
    chk_bit(osc_run_q, 1'b0);
    chk_bit(ext_crystal_ready_flag_q, 1'b0);
    chk_bit(out_32k_en_q, 1'b0);
    chk_bit(irq_q, 1'b0);
    rd(lfo_pkg::IRQ_STAT_OFS, 32'h2, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::IRQ_MASK_OFS, 32'h3, lfo_pkg::RESP_OKAY);
    idle(2);
    chk_bit(irq_q, 1'b1);
    wr(lfo_pkg::IRQ_STAT_OFS, 32'h2, lfo_pkg::RESP_OKAY);
    idle(2);
    chk_bit(irq_q, 1'b0);
    wr(lfo_pkg::EXT_OFS, 32'h00000102, lfo_pkg::RESP_OKAY);
    wait_ready(n);
    chk_bit(n >= 248 && n <= 300, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(lfo_pkg::EXT_OFS, {24'h0, MODES[i][4:3], 6'h02}, lfo_pkg::RESP_OKAY);
      standby_sleep <= MODES[i][2];
      clk_request <= MODES[i][1];
      idle(4);
      chk_bit(osc_run_q, MODES[i][0]);
    end
    standby_sleep <= 1'b0;
    clk_request <= 1'b0;
    wr(lfo_pkg::INT_OFS, 32'hFF7FEFFF, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::INT_OFS, 32'h007F0000, lfo_pkg::RESP_OKAY);
    chk({25'h0, int_osc_trim_q}, 32'h7F);
    wr(lfo_pkg::INT_OFS, 32'h00051000, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::INT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::INT_OFS, 32'h00051000, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::ULP_OFS, 32'h0000009F, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::ULP_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::ULP_OFS, 32'h0000009F, lfo_pkg::RESP_OKAY);
    chk({27'h0, ulp_trim_q}, 32'h1F);
    wr(lfo_pkg::EXT_OFS, 32'h00001002, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::EXT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::EXT_OFS, 32'h00001002, lfo_pkg::RESP_OKAY);
    chk_bit(osc_run_q, 1'b1);
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(lfo_pkg::EXT_OFS, 32'h00000080, lfo_pkg::RESP_OKAY);
    wr(lfo_pkg::EXT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    rd(lfo_pkg::EXT_OFS, 32'h0, lfo_pkg::RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire
